// [pbc_ctrl_status.sv]
// Behaviour
// - writing one to bit 9 restarts negotiation; self-clears once begun
// - without negotiation, bit 8 picks full (1) or half (0) duplex
// - with negotiation enabled, duplex comes from negotiation, bit 8 ignored
// - collision test: col follows tx_en rise within 10 bit times
// - collision test: col drops within 4 bit times of tx_en fall
// - status bit 15 always reads zero
// - status bits 14..11 mirror the advertised technology abilities
// - status bit 5 shows negotiation complete
// - bit 4: partner remote fault with negotiation, else far-end fault
// - status bit 3 always reads one
// - link bit latches low on failure until status is read
// - 10 Mb/s transmission over 105 ms is cut and sets jabber bit
// - jabber event with mask bit set raises management interrupt
// - jabber bit holds until status read, interrupt status read, reset
// - no jabber detection at 100 Mb/s
// - bit 12 enables negotiation; then link setup comes from it alone
`timescale 1ns/10ps
`default_nettype none
`include "pbc_map.svh"

module pbc_ctrl_status #(
    parameter int JABBER_CYC = `PBC_JABBER_CYC
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             mdc,
    input  wire logic             mdio_i,
    output logic                  mdio_o,
    output logic                  mdio_oe,
    input  wire logic [4:0]       phy_addr,
    input  wire logic             an_strap,
    input  wire logic             tx_en,
    input  wire logic [3:0]       adv_ability,
    input  wire pbc_pkg::pbc_an_t an,
    input  wire pbc_pkg::pbc_phy_t phy,
    output logic                  col,
    output logic                  an_restart,
    output logic                  an_enable,
    output logic                  duplex_full,
    output logic                  speed_100,
    output logic                  jabber_cut,
    output logic                  jabber_irq
);
    import pbc_pkg::*;

    localparam int COL_ON_CYC  = `PBC_COL_ON_CYC;
    localparam int COL_OFF_CYC = `PBC_COL_OFF_CYC;
    localparam int JW          = $clog2(JABBER_CYC + 1);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] s_lvl;
    logic [2:0] s_rise;
    logic [2:0] s_fall;
    logic       mdc_rise;
    logic       mdio_bit;
    logic       tx_lvl;

    pbc_sync3 #(.W(3)) u_sync (
        .clock (clock),
        .reset (reset),
        .din   ({tx_en, mdio_i, mdc}),
        .lvl   (s_lvl),
        .rise  (s_rise),
        .fall  (s_fall)
    );

    assign mdc_rise = s_rise[0];
    assign mdio_bit = s_lvl[1];
    assign tx_lvl   = s_lvl[2];

    // ------------------------------------------------------------
    // management frame decode
    // ------------------------------------------------------------
    pbc_state_t  st_r;
    logic [4:0]  cnt_r;
    logic [5:0]  pre_r;
    logic [15:0] sh_r;
    logic        rd_r;
    logic [4:0]  reg_r;
    logic [12:0] hdr_w;
    logic [15:0] wd_w;
    logic        hdr_hit;
    logic        hdr_last;
    logic        stat_rd;
    logic        wr_ev;

    function automatic logic ours(input logic [4:0] a);
        ours = (a == `PBC_REG_CTRL) || (a == `PBC_REG_STAT);
    endfunction

    always_comb begin
        hdr_w    = {sh_r[11:0], mdio_bit};
        wd_w     = {sh_r[14:0], mdio_bit};
        hdr_last = mdc_rise && (st_r == st_hdr) && (cnt_r == `PBC_HDR_LAST);
        hdr_hit  = hdr_w[12] && (hdr_w[9:5] == phy_addr)
                   && ((hdr_w[11:10] == `PBC_OP_WR)
                       || ((hdr_w[11:10] == `PBC_OP_RD) && ours(hdr_w[4:0])));
        stat_rd  = hdr_last && hdr_hit && (hdr_w[11:10] == `PBC_OP_RD)
                   && (hdr_w[4:0] == `PBC_REG_STAT);
        wr_ev    = mdc_rise && (st_r == st_data) && !rd_r
                   && (cnt_r == `PBC_DATA_LAST) && (reg_r == `PBC_REG_CTRL);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r  <= st_pre;
            cnt_r <= '0;
            pre_r <= '0;
            sh_r  <= '0;
            rd_r  <= 1'b0;
            reg_r <= '0;
        end else if (mdc_rise) begin
            case (st_r)
                st_pre: begin
                    cnt_r <= '0;
                    sh_r  <= '0;
                    if (mdio_bit) begin
                        if (pre_r != `PBC_PRE_LEN)
                            pre_r <= pre_r + 6'h01;
                    end else begin
                        pre_r <= '0;
                        if (pre_r == `PBC_PRE_LEN || phy.preamble_en)
                            st_r <= st_hdr;
                    end
                end
                st_hdr: begin
                    sh_r <= wd_w;
                    if (cnt_r == `PBC_HDR_LAST) begin
                        cnt_r <= '0;
                        rd_r  <= (hdr_w[11:10] == `PBC_OP_RD);
                        reg_r <= hdr_w[4:0];
                        st_r  <= hdr_hit ? st_ta : st_skip;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                st_ta: begin
                    if (cnt_r == `PBC_TA_LAST) begin
                        cnt_r <= '0;
                        st_r  <= st_data;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                st_data: begin
                    sh_r <= wd_w;
                    if (cnt_r == `PBC_DATA_LAST) begin
                        st_r <= st_pre;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                st_skip: begin
                    // a frame for someone else is walked past whole, so its
                    // data bits cannot pose as a new start
                    if (cnt_r == `PBC_SKIP_LAST) begin
                        st_r <= st_pre;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                default: begin
                    st_r <= st_pre;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic an_en_r;
    logic speed_r;
    logic duplex_r;
    logic coltest_r;
    logic restart_r;
    logic [15:0] ctrl_w;

    always_ff @(posedge clock) begin
        if (reset) begin
            // straps are sampled by the synchronous reset itself
            an_en_r   <= an_strap;
            speed_r   <= an_strap;
            duplex_r  <= ~an_strap;
            coltest_r <= `PBC_COLTEST_RST;
        end else if (wr_ev) begin
            an_en_r   <= wd_w[`PBC_CTRL_AN_EN];
            speed_r   <= wd_w[`PBC_CTRL_SPEED];
            duplex_r  <= wd_w[`PBC_CTRL_DUPLEX];
            coltest_r <= wd_w[`PBC_CTRL_COLTEST];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            restart_r <= `PBC_RESTART_RST;
        // act-once restart, write of one wins
        end else if (wr_ev && wd_w[`PBC_CTRL_RESTART]) begin
            restart_r <= 1'b1;
        end else if (an.started) begin
            restart_r <= 1'b0;
        end
    end

    // unheld and reserved bits read zero
    always_comb begin
        ctrl_w                     = '0;
        ctrl_w[`PBC_CTRL_SPEED]    = speed_r;
        ctrl_w[`PBC_CTRL_AN_EN]    = an_en_r;
        ctrl_w[`PBC_CTRL_RESTART]  = restart_r;
        ctrl_w[`PBC_CTRL_DUPLEX]   = duplex_r;
        ctrl_w[`PBC_CTRL_COLTEST]  = coltest_r;
    end

    // ------------------------------------------------------------
    // link configuration and collision
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            duplex_full <= 1'b0;
            speed_100   <= 1'b0;
        end else begin
            duplex_full <= an_en_r ? an.duplex_full : duplex_r;
            speed_100   <= an_en_r ? an.speed_100 : speed_r;
        end
    end

    // only 10 Mb/s bit times can be met; three sync stages are 300 ns
    always_ff @(posedge clock) begin
        if (reset) begin
            col <= 1'b0;
        end else begin
            col <= coltest_r ? tx_lvl : phy.col_in;
        end
    end

    // ------------------------------------------------------------
    // jabber and link latches
    // ------------------------------------------------------------
    logic [JW-1:0] jab_cnt_r;
    logic          jab_evt;
    logic          jab_r;
    logic          link_lat_r;

    assign jab_evt = tx_lvl && !speed_100 && !jabber_cut
                     && (jab_cnt_r == JW'(JABBER_CYC));

    always_ff @(posedge clock) begin
        if (reset) begin
            jab_cnt_r  <= '0;
            jabber_cut <= 1'b0;
        end else if (!tx_lvl || speed_100) begin
            jab_cnt_r  <= '0;
            jabber_cut <= 1'b0;
        end else if (jab_cnt_r != JW'(JABBER_CYC)) begin
            jab_cnt_r  <= jab_cnt_r + 1'b1;
        end else begin
            jabber_cut <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            jab_r      <= 1'b0;
            jabber_irq <= 1'b0;
        end else begin
            // sticky, a new event beats the clearing read
            if (jab_evt)
                jab_r <= 1'b1;
            else if (stat_rd || phy.isr_read)
                jab_r <= 1'b0;
            jabber_irq <= jab_evt && phy.jabber_irq_mask;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            link_lat_r <= 1'b0;
        end else if (stat_rd || !phy.link_ok) begin
            link_lat_r <= phy.link_ok;
        end
    end

    // ------------------------------------------------------------
    // status word and read shifter
    // ------------------------------------------------------------
    logic [15:0] stat_w;
    logic [15:0] out_sh_r;

    always_comb begin
        stat_w = '0;
        stat_w[`PBC_STAT_T4] = 1'b0;
        stat_w[`PBC_STAT_ADV_HI:`PBC_STAT_ADV_LO] = adv_ability;
        stat_w[`PBC_STAT_PRE_SUP] = phy.preamble_en;
        stat_w[`PBC_STAT_AN_DONE] = an.complete;
        stat_w[`PBC_STAT_RFAULT] = an_en_r ? an.lp_remote_fault
                                           : phy.far_end_fault;
        stat_w[`PBC_STAT_AN_ABL] = 1'b1;
        stat_w[`PBC_STAT_LINK]   = link_lat_r;
        stat_w[`PBC_STAT_JABBER] = jab_r;
        stat_w[`PBC_STAT_EXT]    = 1'b1;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            out_sh_r <= '0;
            mdio_o   <= 1'b0;
            mdio_oe  <= 1'b0;
        end else if (mdc_rise) begin
            // snapshot taken at the read that clears latches
            if (hdr_last && hdr_hit && hdr_w[11:10] == `PBC_OP_RD) begin
                out_sh_r <= (hdr_w[4:0] == `PBC_REG_STAT) ? stat_w : ctrl_w;
            end else if (st_r == st_ta && rd_r) begin
                mdio_oe <= 1'b1;
                if (cnt_r == `PBC_TA_LAST) begin
                    mdio_o   <= out_sh_r[15];
                    out_sh_r <= {out_sh_r[14:0], 1'b0};
                end else begin
                    mdio_o   <= 1'b0;
                end
            end else if (st_r == st_data && rd_r) begin
                if (cnt_r == `PBC_DATA_LAST) begin
                    mdio_o  <= 1'b0;
                    mdio_oe <= 1'b0;
                end else begin
                    mdio_o   <= out_sh_r[15];
                    out_sh_r <= {out_sh_r[14:0], 1'b0};
                end
            end
        end
    end

    assign an_restart = restart_r;
    assign an_enable  = an_en_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_tx_up;
        (coltest_r && $rose(tx_en)) ##1 (coltest_r && tx_en)[*3];
    endsequence

    sequence s_tx_down;
        (coltest_r && $fell(tx_en)) ##1 (coltest_r && !tx_en)[*3];
    endsequence

    a_restart_clear: assert property (
        restart_r && an.started && !wr_ev |=> !restart_r)
        else $error("restart bit did not self-clear");

    a_restart_zero: assert property (
        wr_ev && !wd_w[`PBC_CTRL_RESTART] && !restart_r |=> !restart_r)
        else $error("writing zero started negotiation");

    a_duplex_manual: assert property (
        !an_en_r |=> duplex_full == $past(duplex_r))
        else $error("manual duplex not applied");

    a_duplex_auto: assert property (
        an_en_r |=> duplex_full == $past(an.duplex_full))
        else $error("negotiated duplex not applied");

    a_col_on_time: assert property (
        s_tx_up |-> ##[0:COL_ON_CYC] col)
        else $error("col late after tx_en rise");

    a_col_off_time: assert property (
        s_tx_down |-> ##[0:COL_OFF_CYC] !col)
        else $error("col late after tx_en fall");

    a_stat_fixed: assert property (
        stat_rd |=> !out_sh_r[`PBC_STAT_T4] && out_sh_r[`PBC_STAT_AN_ABL]
                    && out_sh_r[`PBC_STAT_EXT])
        else $error("fixed status bits wrong");

    a_adv_mirror: assert property (
        stat_rd |=> out_sh_r[`PBC_STAT_ADV_HI:`PBC_STAT_ADV_LO]
                    == $past(adv_ability))
        else $error("ability mirror wrong");

    a_link_low: assert property (
        !phy.link_ok |=> !link_lat_r)
        else $error("link failure not latched");

    a_jab_irq: assert property (
        jab_evt && phy.jabber_irq_mask |=> jabber_irq && jab_r)
        else $error("jabber interrupt missing");

    a_jab_hold: assert property (
        jab_r && !stat_rd && !phy.isr_read |=> jab_r)
        else $error("jabber bit dropped without read");

    a_jab_fast: assert property (
        speed_100 && !jab_r |=> !jab_r && !jabber_cut)
        else $error("jabber seen at 100 Mb/s");

endmodule

`default_nettype wire

// [pbc_mac_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// management master model
// ------------------------------------------------------------
module pbc_mac_model #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic clock,
    input  wire logic mdio_i,
    output logic      mdc,
    output logic      mdio_m,
    output logic      mdio_m_oe
);
    initial begin
        mdc = 1'h0;
        mdio_m = 1'h0;
        mdio_m_oe = 1'h0;
    end

    // data changes in the low half, sampled at the rise; mdc idles low
    task automatic mbit(input logic v, input logic drv, output logic s);
        @(posedge clock);
        mdc       <= 1'h0;
        mdio_m    <= v;
        mdio_m_oe <= drv;
        repeat (4) @(posedge clock);
        mdc <= 1'h1;
        s = mdio_i;
        repeat (3) @(posedge clock);
    endtask

    task automatic xfer(input logic rd, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rdat);
        logic        s;
        logic [13:0] hdr;
        hdr = {2'h1, (rd ? 2'h2 : 2'h1), PHY_ADDR, ra};
        for (int i = 0; i < 32; i++) mbit(1'h1, 1'h1, s);
        for (int i = 13; i >= 0; i--) mbit(hdr[i], 1'h1, s);
        // released on read turnaround, so the pull-up shows
        mbit(1'h1, !rd, s);
        mbit(1'h0, !rd, s);
        for (int i = 15; i >= 0; i--) mbit(wd[i], !rd, rdat[i]);
        @(posedge clock);
        mdc       <= 1'h0;
        mdio_m_oe <= 1'h0;
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// [pbc_map.svh]
`ifndef PBC_MAP_SVH
`define PBC_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define PBC_REG_CTRL      5'h00
`define PBC_REG_STAT      5'h01

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define PBC_CTRL_SPEED    13
`define PBC_CTRL_AN_EN    12
`define PBC_CTRL_RESTART  9
`define PBC_CTRL_DUPLEX   8
`define PBC_CTRL_COLTEST  7

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define PBC_STAT_T4       15
`define PBC_STAT_ADV_HI   14
`define PBC_STAT_ADV_LO   11
`define PBC_STAT_PRE_SUP  6
`define PBC_STAT_AN_DONE  5
`define PBC_STAT_RFAULT   4
`define PBC_STAT_AN_ABL   3
`define PBC_STAT_LINK     2
`define PBC_STAT_JABBER   1
`define PBC_STAT_EXT      0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PBC_COLTEST_RST   1'h0
`define PBC_RESTART_RST   1'h0

// ------------------------------------------------------------
// management frame
// ------------------------------------------------------------
`define PBC_PRE_LEN       6'h20
`define PBC_OP_RD         2'h2
`define PBC_OP_WR         2'h1
`define PBC_HDR_LAST      5'h0c
`define PBC_TA_LAST       5'h01
`define PBC_DATA_LAST     5'h0f
`define PBC_SKIP_LAST     5'h11

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PBC_CLK_NS        100
`define PBC_BIT_NS        100
`define PBC_COL_ON_NS     (10 * `PBC_BIT_NS)
`define PBC_COL_OFF_NS    (4 * `PBC_BIT_NS)
`define PBC_COL_ON_CYC    (`PBC_COL_ON_NS / `PBC_CLK_NS)
`define PBC_COL_OFF_CYC   (`PBC_COL_OFF_NS / `PBC_CLK_NS)
`define PBC_JABBER_MS     105
`define PBC_JABBER_CYC    (`PBC_JABBER_MS * 1000000 / `PBC_CLK_NS)

`endif

// [pbc_pkg.sv]
package pbc_pkg;

    typedef enum logic [2:0] {
        st_pre,
        st_hdr,
        st_ta,
        st_data,
        st_skip
    } pbc_state_t;

    // negotiation results from the auto-negotiation engine
    typedef struct packed {
        logic started;
        logic complete;
        logic lp_remote_fault;
        logic duplex_full;
        logic speed_100;
    } pbc_an_t;

    // levels from neighbouring phy logic, same clock
    typedef struct packed {
        logic link_ok;
        logic far_end_fault;
        logic col_in;
        logic preamble_en;
        logic jabber_irq_mask;
        logic isr_read;
    } pbc_phy_t;

endpackage

// [pbc_sync3.sv]
`timescale 1ns/10ps
`default_nettype none

module pbc_sync3 #(
    parameter int W = 3
) (
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic [W-1:0]      lvl,
    output logic [W-1:0]      rise,
    output logic [W-1:0]      fall
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] held_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            held_r <= '0;
        end else begin
            s1_r   <= din;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            held_r <= lvl;
        end
    end

    // a change counts only once stages two and three agree
    always_comb begin
        lvl  = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & held_r);
        rise = lvl & ~held_r;
        fall = ~lvl & held_r;
    end

endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import pbc_pkg::*;
    logic      clock, reset, mdio_o, mdio_oe, mdc, mdio_m, mdio_m_oe, tx_en;
    logic      col, an_restart, an_enable, duplex_full, speed_100;
    logic      jabber_cut, jabber_irq, an_strap;
    wire logic mdio_i;
    logic [3:0]  adv;
    pbc_an_t     an_s;
    pbc_phy_t    phy_s;
    logic [15:0] d;
    int          error_cnt, n_compared, irq_n;

    assign mdio_i = mdio_oe ? mdio_o : (mdio_m_oe ? mdio_m : 1'h1);

    pbc_ctrl_status #(.JABBER_CYC(200)) uut (
        .clock(clock), .reset(reset), .mdc(mdc), .mdio_i(mdio_i),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr(5'h01),
        .an_strap(an_strap), .tx_en(tx_en), .adv_ability(adv), .an(an_s),
        .phy(phy_s), .col(col), .an_restart(an_restart),
        .an_enable(an_enable), .duplex_full(duplex_full),
        .speed_100(speed_100), .jabber_cut(jabber_cut),
        .jabber_irq(jabber_irq));

    pbc_mac_model #(.PHY_ADDR(5'h01)) mac (
        .clock(clock), .mdio_i(mdio_i), .mdc(mdc), .mdio_m(mdio_m),
        .mdio_m_oe(mdio_m_oe));

    always #50 clock = ~clock;
    always @(posedge clock) if (jabber_irq === 1'h1) irq_n++;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        mac.xfer(1'h1, a, 16'h0000, v);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        logic [15:0] x;
        mac.xfer(1'h0, a, v, x);
        repeat (2) @(posedge clock);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // tx_en held long enough to trip the shortened jabber timer
    task automatic burst;
        @(posedge clock);
        tx_en <= 1'h1;
        tick(260);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        clock = 1'h0;
        reset = 1'h1;
        tx_en = 1'h0;
        an_strap = 1'h0;
        adv = 4'hf;
        an_s = '0;
        phy_s = '0;
        phy_s.link_ok = 1'h1;
        phy_s.preamble_en = 1'h1;
        phy_s.jabber_irq_mask = 1'h1;
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        tick(2);
        rd(5'h00, d); chk("ctrl_rst", 16'h0100, d);
        rd(5'h01, d); chk("stat_rst", 16'h7849, d);
        rd(5'h01, d); chk("stat_link", 16'h784d, d);
        wr(5'h00, 16'hcc7f);
        rd(5'h00, d); chk("ctrl_rsvd", 16'h0000, d);
        chk("half", 16'h0, {15'h0, duplex_full});
        wr(5'h00, 16'h0100);
        chk("full", 16'h1, {15'h0, duplex_full});
        an_s.speed_100 <= 1'h1;
        wr(5'h00, 16'h1100);
        chk("an_dup", 16'h3, {14'h0, speed_100, ~duplex_full});
        chk("an_en", 16'h1, {15'h0, an_enable});
        wr(5'h00, 16'h1300);
        chk("restart", 16'h1, {15'h0, an_restart});
        rd(5'h00, d); chk("ctrl_rs", 16'h1300, d);
        an_s.started <= 1'h1;
        tick(3);
        chk("restart_clr", 16'h0, {15'h0, an_restart});
        an_s.started <= 1'h0;
        wr(5'h00, 16'h1100);
        chk("restart_0", 16'h0, {15'h0, an_restart});
        an_s.complete <= 1'h1;
        an_s.lp_remote_fault <= 1'h1;
        rd(5'h01, d); chk("stat_an", 16'h787d, d);
        wr(5'h00, 16'h0000);
        adv <= 4'ha;
        phy_s.preamble_en <= 1'h0;
        phy_s.far_end_fault <= 1'h1;
        rd(5'h01, d); chk("stat_fef", 16'h503d, d);
        phy_s.far_end_fault <= 1'h0;
        rd(5'h01, d); chk("stat_nofef", 16'h502d, d);
        phy_s.link_ok <= 1'h0;
        tick(3);
        phy_s.link_ok <= 1'h1;
        rd(5'h01, d); chk("link_lat", 16'h5029, d);
        rd(5'h01, d); chk("link_back", 16'h502d, d);
        wr(5'h00, 16'h0080);
        tx_en <= 1'h1;
        tick(10);
        chk("col_on", 16'h1, {15'h0, col});
        tx_en <= 1'h0;
        tick(5);
        chk("col_off", 16'h0, {15'h0, col});
        wr(5'h00, 16'h0000);
        phy_s.col_in <= 1'h1;
        tick(2);
        chk("col_norm", 16'h1, {15'h0, col});
        phy_s.col_in <= 1'h0;
        burst();
        chk("cut", 16'h1, {15'h0, jabber_cut});
        chk("irq", 16'h1, irq_n[15:0]);
        tx_en <= 1'h0;
        rd(5'h01, d); chk("jab_set", 16'h2, d & 16'h0002);
        rd(5'h01, d); chk("jab_clr", 16'h0, d & 16'h0002);
        burst();
        tx_en <= 1'h0;
        phy_s.isr_read <= 1'h1;
        @(posedge clock);
        phy_s.isr_read <= 1'h0;
        rd(5'h01, d); chk("jab_isr", 16'h0, d & 16'h0002);
        wr(5'h00, 16'h2000);
        burst();
        chk("cut_100", 16'h0, {15'h0, jabber_cut});
        tx_en <= 1'h0;
        rd(5'h01, d); chk("jab_100", 16'h0, d & 16'h0002);
        chk("irq_n", 16'h2, irq_n[15:0]);
        // masked jabber: latch sets, no interrupt; then reset clears it
        phy_s.jabber_irq_mask <= 1'h0;
        wr(5'h00, 16'h0000);
        burst();
        chk("irq_mask", 16'h2, irq_n[15:0]);
        tx_en <= 1'h0;
        an_strap <= 1'h1;
        reset <= 1'h1;
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        tick(2);
        chk("an_strap", 16'h1, {15'h0, an_enable});
        rd(5'h00, d); chk("ctrl_strap", 16'h3000, d);
        rd(5'h01, d); chk("jab_rst", 16'h0, d & 16'h0002);
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
